// ===== common/orc_pkg.sv
/*
 * Constants for the on-chip RAM and its address decode.
 * Assumes a 24-bit CPU address and a 16-bit internal data bus.
 */
`default_nettype none
package orc_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int RAM_BYTES = 512;
    localparam int OFS_W = $clog2(RAM_BYTES);
    localparam int IDX_W = OFS_W - 1;
    localparam int RAM_WORDS = RAM_BYTES / 2;
    localparam int MODE_W = 3;
    localparam int ACCESS_STATES = 2;
    // ------------------------------------------------------------
    // RAM window per operating mode
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] WIN_SHORT_LO = 24'h0FFD10;
    localparam logic [ADDR_W-1:0] WIN_SHORT_HI = 24'h0FFF0F;
    localparam logic [ADDR_W-1:0] WIN_LONG_LO = 24'hFFFD10;
    localparam logic [ADDR_W-1:0] WIN_LONG_HI = 24'hFFFF0F;
    localparam int SHORT_ADDR_W = 20;
    localparam logic [MODE_W-1:0] MODE_1 = 3'h1;
    localparam logic [MODE_W-1:0] MODE_2 = 3'h2;
    localparam logic [MODE_W-1:0] MODE_3 = 3'h3;
    localparam logic [MODE_W-1:0] MODE_4 = 3'h4;
    localparam logic [MODE_W-1:0] MODE_RESET = 3'h0;
    // ------------------------------------------------------------
    // System control register
    // ------------------------------------------------------------
    localparam logic [15:0] SYS_CTRL_ADDR = 16'hFFF2;
    localparam logic [BYTE_W-1:0] SYS_CTRL_RESET = 8'h0B;
    localparam int GATE_BIT = 0;
    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_T2 = 2'h1
    } orc_state_type;
endpackage : orc_pkg
`default_nettype wire

// ===== common/orc_ram_if.sv
/*
 * Port of the RAM array: word index, byte-lane write strobes, data.
 * Assumes the array reads combinationally and writes on the clock.
 */
`default_nettype none
interface orc_ram_if;
    logic [orc_pkg::IDX_W-1:0] idx;
    logic wr_hi;
    logic wr_lo;
    logic [orc_pkg::DATA_W-1:0] wdata;
    logic [orc_pkg::DATA_W-1:0] rdata;
    modport ctrl (output idx, output wr_hi, output wr_lo, output wdata,
                  input rdata);
    modport mem (input idx, input wr_hi, input wr_lo, input wdata,
                 output rdata);
endinterface : orc_ram_if
`default_nettype wire

// ===== logic/orc_ram_array.sv
/*
 * 256 x 16 static RAM with separate upper and lower byte lanes.
 * Assumes strobes are single-cycle and qualified by the clock enable.
 */
`default_nettype none
module orc_ram_array (
    // Clock
    input wire logic clk,
    input wire logic ce,
    // Array port
    orc_ram_if.mem bus
);
    logic [orc_pkg::DATA_W-1:0] mem_q [orc_pkg::RAM_WORDS];

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // Contents are not reset; RAM holds whatever was written last
    always_ff @(posedge clk) begin
        if (ce && bus.wr_hi) begin
            mem_q[bus.idx][15:8] <= bus.wdata[15:8];
        end
        if (ce && bus.wr_lo) begin
            mem_q[bus.idx][7:0] <= bus.wdata[7:0];
        end
    end

    assign bus.rdata = mem_q[bus.idx];
endmodule : orc_ram_array
`default_nettype wire

// ===== logic/orc_ram_top.sv
/*
 * On-chip RAM controller: window decode, two-state access sequencer,
 * system control register with the RAM gate bit.
 * Assumes the CPU holds a request until it is taken and waits for the
 * acknowledge before issuing the next one.
 */
`default_nettype none

module orc_ram_top (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    input wire logic ce,
    // Mode pins and power state
    input wire logic [orc_pkg::MODE_W-1:0] mode_pins,
    input wire logic soft_standby,
    // CPU access
    input wire logic cpu_req,
    input wire logic [orc_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_wr,
    input wire logic cpu_word,
    input wire logic [orc_pkg::DATA_W-1:0] cpu_wdata,
    output logic cpu_ack,
    output logic [orc_pkg::DATA_W-1:0] cpu_rdata,
    // External space hand-off
    output logic ext_req,
    output logic [orc_pkg::ADDR_W-1:0] ext_addr,
    // Control register view
    output logic onchip_ram_gate,
    output logic [orc_pkg::BYTE_W-1:0] system_control_register
);
    // ------------------------------------------------------------
    // Decode functions
    // ------------------------------------------------------------
    function automatic logic in_window(
        input logic [orc_pkg::ADDR_W-1:0] a,
        input logic [orc_pkg::MODE_W-1:0] m
    );
        logic [orc_pkg::ADDR_W-1:0] s;
        s = {4'h0, a[orc_pkg::SHORT_ADDR_W-1:0]};
        case (m)
            orc_pkg::MODE_1, orc_pkg::MODE_2: begin
                in_window = s >= orc_pkg::WIN_SHORT_LO &&
                            s <= orc_pkg::WIN_SHORT_HI;
            end
            orc_pkg::MODE_3, orc_pkg::MODE_4: begin
                in_window = a >= orc_pkg::WIN_LONG_LO &&
                            a <= orc_pkg::WIN_LONG_HI;
            end
            default: begin
                in_window = 1'b0;
            end
        endcase
    endfunction : in_window

    function automatic logic [orc_pkg::OFS_W-1:0] win_offset(
        input logic [orc_pkg::ADDR_W-1:0] a
    );
        // Both windows share their low twenty bits, so one base serves
        logic [orc_pkg::ADDR_W-1:0] d;
        d = a - orc_pkg::WIN_LONG_LO;
        win_offset = d[orc_pkg::OFS_W-1:0];
    endfunction : win_offset

    // ------------------------------------------------------------
    // Mode pin synchroniser
    // ------------------------------------------------------------
    logic [orc_pkg::MODE_W-1:0] m1_reg, m2_reg, m3_reg, mode_reg;
    logic [orc_pkg::MODE_W-1:0] mode_next;

    always_comb begin
        mode_next = mode_reg;
        if (m2_reg == m3_reg) begin
            mode_next = m3_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            m1_reg <= orc_pkg::MODE_RESET;
            m2_reg <= orc_pkg::MODE_RESET;
            m3_reg <= orc_pkg::MODE_RESET;
            mode_reg <= orc_pkg::MODE_RESET;
        end else if (ce) begin
            m1_reg <= mode_pins;
            m2_reg <= m1_reg;
            m3_reg <= m2_reg;
            mode_reg <= mode_next;
        end
    end

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    orc_ram_if ram_bus ();

    orc_ram_array u_array (
        .clk(clk),
        .ce(ce),
        .bus(ram_bus)
    );

    orc_pkg::orc_state_type st_reg, st_next;
    logic [orc_pkg::OFS_W-1:0] ofs_reg, ofs_next;
    logic wr_reg, wr_next, word_reg, word_next, sys_reg, sys_next;
    logic [orc_pkg::DATA_W-1:0] wd_reg, wd_next, rd_reg, rd_next;
    logic ack_reg, ack_next, ext_reg, ext_next;
    logic [orc_pkg::ADDR_W-1:0] ea_reg, ea_next;
    logic [orc_pkg::BYTE_W-1:0] ctl_reg, ctl_next;
    logic take, hit_ram, hit_sys;
    logic [orc_pkg::BYTE_W-1:0] lane;

    assign hit_ram = in_window(cpu_addr, mode_reg);
    assign hit_sys = cpu_addr[15:0] == orc_pkg::SYS_CTRL_ADDR;
    // A halted CPU in standby issues nothing; requests then are ignored.
    // The answer cycle takes nothing: the CPU still holds its request there,
    // and taking it again would repeat the access, on chip or on the external bus
    assign take = cpu_req && !soft_standby && st_reg == orc_pkg::ST_IDLE &&
                  !ack_reg && !ext_reg;
    // word index into the 512-byte array
    assign ram_bus.idx = ofs_reg[orc_pkg::OFS_W-1:1];
    assign lane = ofs_reg[0] ? ram_bus.rdata[7:0] : ram_bus.rdata[15:8];

    always_comb begin
        st_next = st_reg;
        ofs_next = ofs_reg;
        wr_next = wr_reg;
        word_next = word_reg;
        sys_next = sys_reg;
        wd_next = wd_reg;
        rd_next = rd_reg;
        ea_next = ea_reg;
        ctl_next = ctl_reg;
        ack_next = 1'b0;
        ext_next = 1'b0;
        ram_bus.wr_hi = 1'b0;
        ram_bus.wr_lo = 1'b0;
        ram_bus.wdata = wd_reg;
        case (st_reg)
            orc_pkg::ST_IDLE: begin
                // gate low sends window hits outside
                if (take && hit_ram && ctl_reg[orc_pkg::GATE_BIT]) begin
                    st_next = orc_pkg::ST_T2;
                    sys_next = 1'b0;
                end else if (take && hit_sys && !hit_ram) begin
                    st_next = orc_pkg::ST_T2;
                    sys_next = 1'b1;
                end else if (take) begin
                    ext_next = 1'b1;
                    ea_next = cpu_addr;
                end
                if (take) begin
                    ofs_next = win_offset(cpu_addr);
                    wr_next = cpu_wr;
                    word_next = cpu_word;
                    wd_next = cpu_wdata;
                end
            end
            orc_pkg::ST_T2: begin
                st_next = orc_pkg::ST_IDLE;
                ack_next = 1'b1;
                if (sys_reg) begin
                    rd_next = {ctl_reg, 8'h00};
                    // write updates the gate and stores the rest
                    if (wr_reg) begin
                        ctl_next = wd_reg[15:8];
                    end
                end else if (word_reg) begin
                    // word uses both lanes, odd address aligns down
                    rd_next = ram_bus.rdata;
                    ram_bus.wr_hi = wr_reg;
                    ram_bus.wr_lo = wr_reg;
                end else begin
                    // byte travels on the upper lines
                    rd_next = {lane, 8'h00};
                    ram_bus.wdata = {wd_reg[15:8], wd_reg[15:8]};
                    ram_bus.wr_hi = wr_reg && !ofs_reg[0];
                    ram_bus.wr_lo = wr_reg && ofs_reg[0];
                end
            end
            default: begin
                st_next = orc_pkg::ST_IDLE;
            end
        endcase
        if (!ce) begin
            ram_bus.wr_hi = 1'b0;
            ram_bus.wr_lo = 1'b0;
        end
    end

    // gate and register reset only by the reset pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= orc_pkg::ST_IDLE;
            ofs_reg <= '0;
            wr_reg <= 1'b0;
            word_reg <= 1'b0;
            sys_reg <= 1'b0;
            wd_reg <= '0;
            rd_reg <= '0;
            ea_reg <= '0;
            ctl_reg <= orc_pkg::SYS_CTRL_RESET;
            ack_reg <= 1'b0;
            ext_reg <= 1'b0;
        end else if (ce) begin
            st_reg <= st_next;
            ofs_reg <= ofs_next;
            wr_reg <= wr_next;
            word_reg <= word_next;
            sys_reg <= sys_next;
            wd_reg <= wd_next;
            rd_reg <= rd_next;
            ea_reg <= ea_next;
            ctl_reg <= ctl_next;
            ack_reg <= ack_next;
            ext_reg <= ext_next;
        end
    end

    assign cpu_ack = ack_reg;
    assign cpu_rdata = rd_reg;
    assign ext_req = ext_reg;
    assign ext_addr = ea_reg;
    assign onchip_ram_gate = ctl_reg[orc_pkg::GATE_BIT];
    assign system_control_register = ctl_reg;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_ram_take;
        ce && take && hit_ram && ctl_reg[orc_pkg::GATE_BIT];
    endsequence
    sequence s_finish;
        ce && st_reg == orc_pkg::ST_T2;
    endsequence

    chk_two_state: assert property (s_ram_take ##1 s_finish |=> cpu_ack)
        else $error("RAM access did not end in two states");
    chk_window_hit: assert property (s_ram_take |=>
        st_reg == orc_pkg::ST_T2 && !ext_req)
        else $error("window hit not served on chip");
    chk_index_range: assert property (s_ram_take |->
        20'(cpu_addr[orc_pkg::SHORT_ADDR_W-1:0] -
            orc_pkg::WIN_LONG_LO[orc_pkg::SHORT_ADDR_W-1:0]) <
        20'(orc_pkg::RAM_BYTES))
        else $error("window offset outside the array");
    chk_gate_off_ext: assert property (ce && take && hit_ram &&
        !ctl_reg[orc_pkg::GATE_BIT] |=> ext_req && ext_addr == $past(cpu_addr)
        && st_reg == orc_pkg::ST_IDLE)
        else $error("gated window access not routed out");
    chk_gate_write: assert property ((s_finish and (sys_reg && wr_reg)) |=>
        onchip_ram_gate == $past(wd_reg[8]))
        else $error("gate did not follow the write");
    chk_gate_hold: assert property (
        !(ce && st_reg == orc_pkg::ST_T2 && sys_reg && wr_reg) |=>
        $stable(onchip_ram_gate))
        else $error("gate changed without a write");
    chk_byte_lane: assert property ((s_finish and (!word_reg)) |=>
        cpu_rdata[7:0] == 8'h00)
        else $error("byte data off the upper lines");
    chk_word_read: assert property (
        (s_finish and (word_reg && !sys_reg)) |=>
        cpu_rdata == $past(ram_bus.rdata) && cpu_ack)
        else $error("word read not on all lines");
    chk_sys_read: assert property ((s_finish and (sys_reg && !wr_reg)) |=>
        cpu_rdata[15:8] == system_control_register)
        else $error("control register read wrong");
    chk_ctl_store: assert property ((s_finish and (sys_reg && wr_reg)) |=>
        system_control_register == $past(wd_reg[15:8]))
        else $error("control register write lost");
endmodule : orc_ram_top
`default_nettype wire

// ===== tb/orc_cpu_model.sv
/*
 * CPU side model: one access per go pulse, held until answered.
 * Assumes one clock shared with the RAM block.
 */
`default_nettype none
module orc_cpu_model (
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Command from the bench
    input wire logic go,
    input wire logic [23:0] c_addr,
    input wire logic c_wr,
    input wire logic c_word,
    input wire logic [15:0] c_wdata,
    // Bus toward the RAM block
    output logic cpu_req,
    output logic [23:0] cpu_addr,
    output logic cpu_wr,
    output logic cpu_word,
    output logic [15:0] cpu_wdata,
    input wire logic cpu_ack,
    input wire logic ext_req,
    input wire logic [15:0] cpu_rdata,
    // Outcome
    output logic done,
    output logic got_ext,
    output logic [3:0] lat,
    output logic [15:0] rd
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------------------------------------------------------------
    // Request held until ack or hand-off, then released
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_req <= 1'h0;
            cpu_addr <= 24'h000000;
            cpu_wr <= 1'h0;
            cpu_word <= 1'h0;
            cpu_wdata <= 16'h0000;
            done <= 1'h0;
            got_ext <= 1'h0;
            lat <= 4'h0;
            rd <= 16'h0000;
        end else begin
            done <= 1'h0;
            if (cpu_req) begin
                lat <= lat + 4'h1;
                if (cpu_ack || ext_req) begin
                    cpu_req <= 1'h0;
                    done <= 1'h1;
                    got_ext <= ext_req;
                    rd <= cpu_rdata;
                    // Released address, data and write lines flip so stale values never match
                    cpu_addr <= ~cpu_addr;
                    cpu_wdata <= ~cpu_wdata;
                    cpu_wr <= ~cpu_wr;
                end
            end else if (go) begin
                cpu_req <= 1'h1;
                cpu_addr <= c_addr;
                cpu_wr <= c_wr;
                cpu_word <= c_word;
                cpu_wdata <= c_wdata;
                lat <= 4'h0;
            end
        end
    end
endmodule : orc_cpu_model
`default_nettype wire

// ===== tb/onchip_ram_with_enable_decode_bench.sv
/*
 * Self-checking bench for the on-chip RAM and its decode.
 * Assumes the CPU model above on the far side and mode 3 by default.
 */
`default_nettype none
module onchip_ram_with_enable_decode_bench;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [23:0] a; logic w; logic wd; logic [15:0] d;
        logic x; logic [15:0] r;
    } orc_row_type;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic [2:0] mode_pins = 3'h3;
    logic soft_standby = 1'h0;
    logic ce = 1'h1;
    logic go = 1'h0;
    logic [23:0] c_addr = 24'h000000;
    logic c_wr = 1'h0;
    logic c_word = 1'h0;
    logic [15:0] c_wdata = 16'h0000;
    logic cpu_req, cpu_wr, cpu_word, cpu_ack, ext_req, gate;
    logic done, got_ext, ok;
    logic [23:0] cpu_addr, ext_addr, a;
    logic [15:0] cpu_wdata, cpu_rdata, rd;
    logic [7:0] sysreg;
    logic [3:0] lat;
    int mismatches = 0;
    int tests_run = 0;
    orc_row_type rows [16] = '{
        '{24'h00FFF2, 1'h0, 1'h0, 16'h0000, 1'h0, 16'h0B00},
        '{24'hFFFD10, 1'h1, 1'h1, 16'h1234, 1'h0, 16'h0000},
        '{24'hFFFD10, 1'h0, 1'h1, 16'h0000, 1'h0, 16'h1234},
        '{24'hFFFD12, 1'h1, 1'h0, 16'hAB00, 1'h0, 16'h0000},
        '{24'hFFFD13, 1'h1, 1'h0, 16'hCD00, 1'h0, 16'h0000},
        '{24'hFFFD12, 1'h0, 1'h1, 16'h0000, 1'h0, 16'hABCD},
        '{24'hFFFD13, 1'h0, 1'h0, 16'h0000, 1'h0, 16'hCD00},
        '{24'hFFFF0E, 1'h1, 1'h1, 16'h5A5A, 1'h0, 16'h0000},
        '{24'hFFFF0F, 1'h0, 1'h0, 16'h0000, 1'h0, 16'h5A00},
        '{24'hFFFF10, 1'h0, 1'h1, 16'h0000, 1'h1, 16'h0000},
        '{24'hFFFD0F, 1'h0, 1'h0, 16'h0000, 1'h1, 16'h0000},
        '{24'h00FFF2, 1'h1, 1'h0, 16'h0A00, 1'h0, 16'h0000},
        '{24'hFFFD10, 1'h0, 1'h1, 16'h0000, 1'h1, 16'h0000},
        '{24'h00FFF2, 1'h0, 1'h0, 16'h0000, 1'h0, 16'h0A00},
        '{24'h00FFF2, 1'h1, 1'h0, 16'h0B00, 1'h0, 16'h0000},
        '{24'hFFFD10, 1'h0, 1'h1, 16'h0000, 1'h0, 16'h1234}
    };
    always #25 clk = ~clk;
    orc_cpu_model orc_cpu_model_i (.clk(clk), .arst_n(arst_n), .go(go),
        .c_addr(c_addr), .c_wr(c_wr), .c_word(c_word), .c_wdata(c_wdata),
        .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack),
        .ext_req(ext_req), .cpu_rdata(cpu_rdata), .done(done),
        .got_ext(got_ext), .lat(lat), .rd(rd));
    // Clock enable driven here so that the freeze can be seen
    orc_ram_top orc_ram_top_i (.clk(clk), .arst_n(arst_n), .ce(ce),
        .mode_pins(mode_pins), .soft_standby(soft_standby),
        .cpu_req(cpu_req), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
        .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_ack(cpu_ack),
        .cpu_rdata(cpu_rdata), .ext_req(ext_req), .ext_addr(ext_addr),
        .onchip_ram_gate(gate), .system_control_register(sysreg));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : close_out
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task wt(input int lim, input logic must);
        ok = 1'h0;
        for (int n = 0; n < lim && !ok; n++) begin
            @(posedge clk);
            #1;
            ok = (done === 1'h1);
        end
        if (must && !ok) begin
            mismatches++;
            close_out();
        end
    endtask : wt
    task acc(input logic [23:0] ad, input logic w, input logic wd,
             input logic [15:0] d, input int lim, input logic must);
        @(posedge clk);
        go <= 1'h1;
        c_addr <= ad;
        c_wr <= w;
        c_word <= wd;
        c_wdata <= d;
        @(posedge clk);
        go <= 1'h0;
        wt(lim, must);
    endtask : acc
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        arst_n <= 1'h1;
        repeat (6) @(posedge clk);
        chk("gate", 24'h1, 24'(gate));
        chk("sysreg", 24'h0B, 24'(sysreg));
        foreach (rows[i]) begin
            acc(rows[i].a, rows[i].w, rows[i].wd, rows[i].d, 20, 1'h1);
            chk("ext", 24'(rows[i].x), 24'(got_ext));
            chk("lat", rows[i].x ? 24'h2 : 24'h3, 24'(lat));
            if (rows[i].x)
                chk("ext_addr", rows[i].a, ext_addr);
            if (!rows[i].w && !rows[i].x)
                chk("rdata", 24'(rows[i].r), 24'(rd));
            if (rows[i].w && rows[i].a[15:0] == 16'hFFF2)
                chk("gate", 24'(rows[i].d[8]), 24'(gate));
        end
        // Every mode pin value, window hit or hand-off
        for (int m = 0; m < 8; m++) begin
            @(posedge clk);
            mode_pins <= 3'(m);
            repeat (8) @(posedge clk);
            a = (m == 3 || m == 4) ? 24'hFFFD10 : 24'h0FFD10;
            acc(a, 1'h0, 1'h1, 16'h0000, 20, 1'h1);
            chk("mode_ext", 24'(!(m >= 1 && m <= 4)), 24'(got_ext));
            if (m >= 1 && m <= 4)
                chk("mode_rd", 24'h1234, 24'(rd));
        end
        @(posedge clk);
        mode_pins <= 3'h3;
        // Standby holds off the request and leaves the gate alone
        soft_standby <= 1'h1;
        acc(24'h00FFF2, 1'h1, 1'h0, 16'h0A00, 8, 1'h0);
        chk("standby", 24'h0, 24'(ok));
        chk("gate", 24'h1, 24'(gate));
        @(posedge clk);
        soft_standby <= 1'h0;
        wt(20, 1'h1);
        chk("gate", 24'h0, 24'(gate));
        // Mid-run reset restores the gate
        @(posedge clk);
        arst_n <= 1'h0;
        repeat (2) @(posedge clk);
        chk("gate", 24'h1, 24'(gate));
        chk("sysreg", 24'h0B, 24'(sysreg));
        arst_n <= 1'h1;
        repeat (6) @(posedge clk);
        acc(24'hFFFD10, 1'h0, 1'h1, 16'h0000, 20, 1'h1);
        chk("after_rst", 24'h0, 24'(got_ext));
        chk("after_rst_rd", 24'h1234, 24'(rd));
        // Clock enable low freezes the block, so the request must wait
        @(posedge clk);
        ce <= 1'h0;
        acc(24'hFFFD10, 1'h0, 1'h1, 16'h0000, 6, 1'h0);
        chk("ce_hold", 24'h0, 24'(ok));
        @(posedge clk);
        ce <= 1'h1;
        wt(20, 1'h1);
        chk("ce_ext", 24'h0, 24'(got_ext));
        chk("ce_rd", 24'h1234, 24'(rd));
        close_out();
    end
endmodule : onchip_ram_with_enable_decode_bench
`default_nettype wire
